// ===== include/timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define TMR_ADDR_W 8
`define TMR_CNT_W 16
`define TMR_PRE_W 8
`define TMR_DB_W 8
`define TMR_DB_MAX 128

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMR_OFF_CTL0 8'h00
`define TMR_OFF_CTL1 8'h04
`define TMR_OFF_COUNT 8'h08
`define TMR_OFF_MATCH 8'h0c
`define TMR_OFF_RELOAD 8'h10
`define TMR_OFF_PRESCALE 8'h14
`define TMR_OFF_DEADBAND 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR_CTL0_MODEHI 0
`define TMR_CTL0_ISEL_LO 1
`define TMR_CTL0_ISEL_HI 2
`define TMR_CTL0_FLAG 3
`define TMR_CTL1_MODE_LO 0
`define TMR_CTL1_MODE_HI 2
`define TMR_CTL1_POL 6
`define TMR_CTL1_EN 7

// ----------------------------------------------------------------
// Count values
// ----------------------------------------------------------------
`define TMR_RESTART 16'h0001

`endif

// ===== include/timer_pkg.sv
package timer_pkg;

    // Combined mode code: {mode_high_bit, mode_field}.
    typedef enum logic [3:0] {
        MODE_PWM_SINGLE = 4'b0011,
        MODE_CAPTURE = 4'b0100,
        MODE_PWM_DUAL = 4'b1000
    } mode_t;

    // Interrupt source selection.
    typedef enum logic [1:0] {
        ISEL_BOTH = 2'b00,
        ISEL_CAPTURE = 2'b01,
        ISEL_RELOAD = 2'b10,
        ISEL_BOTH_ALT = 2'b11
    } irq_sel_t;

endpackage

// ===== include/deadband_if.sv
`timescale 1ns/100ps
`include "timer_defs.svh"

// Request level, delay and delayed level of one output channel.
interface deadband_if #(
    parameter int DB_W = `TMR_DB_W
);
    logic req;
    logic [DB_W-1:0] delay;
    logic level;

    modport ctrl (output req, output delay, input level);
    modport unit (input req, input delay, output level);
endinterface

// ===== design/deadband_delay.sv
`timescale 1ns/100ps
`include "timer_defs.svh"

// ----------------------------------------------------------------
// Deadband delay for one output
// ----------------------------------------------------------------
// Rising requests wait the deadband;
// falling ones pass after one cycle.
module deadband_delay #(
    parameter int DB_W = `TMR_DB_W
) (
    input logic ref_clk,
    input logic rst_n,
    deadband_if.unit db
);
    logic [DB_W-1:0] cnt_q; // Cycles waited since the request rose.
    logic level_q; // Delayed output level.

    // The count restarts whenever the request drops, so a new rising
    // request always waits the whole deadband again.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!db.req || level_q) begin
            cnt_q <= '0; // R20
        end else if (cnt_q < db.delay) begin
            cnt_q <= cnt_q + 1'b1; // R11
        end
    end

    // Output level: low at once, high only when the wait is over.
    // A zero delay lets the rise through on the next edge.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (!db.req) begin
            level_q <= 1'b0; // R11
        end else if (cnt_q >= db.delay) begin
            level_q <= 1'b1; // R20
        end
    end

    assign db.level = level_q;
endmodule

// ===== design/pwm_capture_timer.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`include "timer_defs.svh"

// Summary of operation
// R1: PWM and capture count prescaled system clock.
// R2: Count up; toggle output at match value.
// R3: At reload: interrupt, count to 0001, continue.
// R4: Polarity one: start high, low at match.
// R5: Polarity zero: start low, high at match.
// R6: Loaded start count affects first period only.
// R7: Software keeps reload above match value.
// R8: Period equals reload times prescale factor.
// R9: Software configures while disabled, then enables.
// R10: Dual mode drives inverse output on pin.
// R11: Dual mode delays rising edges by deadband.
// R12: Software keeps deadband below both phases.
// R13: Dual mode turns input pin into output.
// R14: Software sets dual mode via both mode bits.
// R15: Capture copies count into match on edge.
// R16: Capture raises interrupt, sets flag, keeps counting.
// R17: Capture-mode reload interrupts, clears flag, continues.
// R18: Interrupt source selectable: both, capture, reload.
// R19: Software clears match before capture mode.
// R20: Per-output deadband counter, restarts, zero immediate.
module pwm_capture_timer
    import timer_pkg::*;
#(
    parameter int CNT_W = `TMR_CNT_W,
    parameter int PRE_W = `TMR_PRE_W,
    parameter int DB_W = `TMR_DB_W
) (
    input logic ref_clk,
    input logic arst_n,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [`TMR_ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic tin_in,
    output logic tin_out,
    output logic tin_oe,
    output logic tout,
    output logic timer_irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The count must fit a bus word;
    // the deadband field must hold its top value.
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
        $error("CNT_W must lie between 2 and 32");
    end
    if (PRE_W < 1 || PRE_W > 32) begin : g_bad_pre
        $error("PRE_W must lie between 1 and 32");
    end
    if (DB_W < 1 || DB_W > 31 || (2 ** DB_W) <= `TMR_DB_MAX)
    begin : g_bad_db
        $error("DB_W too narrow for the largest deadband");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q; // First stage, read only by the second.
    logic rst_n; // Released reset used by everything else.

    // Reset asserts at once and releases two edges later.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic mode_high_bit_q; // Upper mode bit in control_reg_zero.
    irq_sel_t irq_source_select_q; // Which events interrupt.
    logic capture_cause_flag_q; // Set by a capture, cleared by a capture-mode reload.
    logic en_q; // Timer enable.
    logic output_polarity_select_q; // Start level and capture edge.
    logic [2:0] mode_field_q; // Lower mode bits in control_reg_one.
    logic [CNT_W-1:0] count_q; // Running count.
    logic [CNT_W-1:0] match_q; // PWM match, or captured count.
    logic [CNT_W-1:0] reload_q; // Reload value.
    logic [PRE_W-1:0] prescale_q; // Prescale factor, zero acts as one.
    logic [DB_W-1:0] deadband_q; // Deadband in clock cycles.
    logic [PRE_W-1:0] div_q; // Prescale divider.
    logic pwm_lvl_q; // Undelayed PWM level.
    logic tin_prev_q; // Input pin one cycle ago.
    logic irq_q; // Interrupt pulse.
    logic [31:0] prdata_q; // Read data taken in the setup cycle.

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic hit; // Address names a register.
    logic wr_en; // Write takes effect at this edge.
    logic rd_setup; // Read address is being presented.
    logic [31:0] rd_mux; // Read value for the current address.

    assign wr_en = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;
    // Zero wait states: pready stands
    // in the first access cycle.
    assign pready = psel && penable;
    assign pslverr = psel && penable && !hit;
    assign prdata = prdata_q;

    // Read multiplexer; unused upper bits read as zero.
    always_comb begin
        hit = 1'b1;
        rd_mux = '0;
        case (paddr)
            `TMR_OFF_CTL0: begin
                rd_mux[`TMR_CTL0_MODEHI] = mode_high_bit_q;
                rd_mux[`TMR_CTL0_ISEL_HI:`TMR_CTL0_ISEL_LO] =
                    irq_source_select_q;
                rd_mux[`TMR_CTL0_FLAG] = capture_cause_flag_q;
            end
            `TMR_OFF_CTL1: begin
                rd_mux[`TMR_CTL1_MODE_HI:`TMR_CTL1_MODE_LO] =
                    mode_field_q;
                rd_mux[`TMR_CTL1_POL] = output_polarity_select_q;
                rd_mux[`TMR_CTL1_EN] = en_q;
            end
            `TMR_OFF_COUNT: rd_mux[CNT_W-1:0] = count_q;
            `TMR_OFF_MATCH: rd_mux[CNT_W-1:0] = match_q;
            `TMR_OFF_RELOAD: rd_mux[CNT_W-1:0] = reload_q;
            `TMR_OFF_PRESCALE: rd_mux[PRE_W-1:0] = prescale_q;
            `TMR_OFF_DEADBAND: rd_mux[DB_W-1:0] = deadband_q;
            default: begin
                hit = 1'b0; // Unmapped: error answer, zero data.
            end
        endcase
    end

    // Read data is taken in the setup cycle, so a
    // live count reads one cycle old.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= '0;
        end else if (rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    mode_t mode; // Combined mode code.
    logic is_pwm; // Running in either PWM mode.
    logic is_dual; // Dual-output mode selected.
    logic is_cap; // Running in capture mode.
    logic run; // Counter advances.

    assign mode = mode_t'({mode_high_bit_q, mode_field_q});

    // Modes outside this block leave the counter stopped.
    always_comb begin
        is_pwm = 1'b0;
        is_dual = 1'b0;
        is_cap = 1'b0;
        case (mode)
            MODE_PWM_SINGLE: is_pwm = en_q;
            MODE_PWM_DUAL: begin
                is_pwm = en_q;
                is_dual = 1'b1; // R13
            end
            MODE_CAPTURE: is_cap = en_q;
            default: is_pwm = 1'b0;
        endcase
    end

    assign run = is_pwm || is_cap;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic wr_ctl1; // Write to control_reg_one.

    assign wr_ctl1 = wr_en && (paddr == `TMR_OFF_CTL1);

    // Software-written control fields.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_high_bit_q <= 1'b0;
            irq_source_select_q <= ISEL_BOTH; // R18
            en_q <= 1'b0;
            output_polarity_select_q <= 1'b0;
            mode_field_q <= '0;
        end else if (wr_en && paddr == `TMR_OFF_CTL0) begin
            mode_high_bit_q <= pwdata[`TMR_CTL0_MODEHI];
            irq_source_select_q <= irq_sel_t'(
                pwdata[`TMR_CTL0_ISEL_HI:`TMR_CTL0_ISEL_LO]);
        end else if (wr_ctl1) begin
            mode_field_q <= pwdata[`TMR_CTL1_MODE_HI:`TMR_CTL1_MODE_LO];
            output_polarity_select_q <= pwdata[`TMR_CTL1_POL];
            en_q <= pwdata[`TMR_CTL1_EN];
        end
    end

    // Reload, prescale and deadband; deadband beyond the
    // largest legal value is held at that value.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= '0;
            prescale_q <= '0;
            deadband_q <= '0;
        end else if (wr_en) begin
            if (paddr == `TMR_OFF_RELOAD) begin
                reload_q <= pwdata[CNT_W-1:0];
            end
            if (paddr == `TMR_OFF_PRESCALE) begin
                prescale_q <= pwdata[PRE_W-1:0];
            end
            if (paddr == `TMR_OFF_DEADBAND) begin
                if (pwdata > `TMR_DB_MAX) begin
                    deadband_q <= DB_W'(`TMR_DB_MAX); // R11
                end else begin
                    deadband_q <= pwdata[DB_W-1:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    logic [PRE_W-1:0] div_last; // Last divider value of a tick.
    logic tick; // Count advance strobe.

    // Only the system clock feeds the count; no pin is sampled.
    assign div_last = (prescale_q == '0) ? '0 : prescale_q - 1'b1;
    assign tick = run && (div_q == div_last); // R1

    // A write to control_reg_one restarts the divider,
    // so the first tick is a full factor late.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (!run || wr_ctl1 || tick) begin
            div_q <= '0; // R8
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic at_reload; // Count stands at reload on a tick.
    logic at_match; // Count stands at match on a tick.
    logic cap_edge; // Selected input edge in capture mode.
    logic irq_on_cap; // Capture events may interrupt.
    logic irq_on_reload; // Reload events may interrupt.

    assign at_reload = tick && (count_q == reload_q);
    assign at_match = tick && is_pwm && (count_q == match_q); // R2

    // Polarity one selects the rising edge, zero the falling.
    // The pin carries an output in dual mode, where its edges cause no capture.
    assign cap_edge = is_cap && (output_polarity_select_q ?
        (tin_in && !tin_prev_q) : (!tin_in && tin_prev_q)); // R15

    assign irq_on_cap = (irq_source_select_q != ISEL_RELOAD); // R18
    assign irq_on_reload = (irq_source_select_q != ISEL_CAPTURE);

    // Previous input level for edge detection.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tin_prev_q <= 1'b0;
        end else begin
            tin_prev_q <= tin_in;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Software loads the start count; PWM
    // periods then restart after reload.
    // Capture mode wraps at full scale.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (wr_en && paddr == `TMR_OFF_COUNT) begin
            count_q <= pwdata[CNT_W-1:0]; // R6
        end else if (at_reload && is_pwm) begin
            count_q <= CNT_W'(`TMR_RESTART); // R3
        end else if (tick) begin
            count_q <= count_q + 1'b1; // R16
        end
    end

    // Match register: software value, overwritten by a capture.
    // A capture in the same cycle as a write wins.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_q <= '0;
        end else if (cap_edge) begin
            match_q <= count_q; // R15
        end else if (wr_en && paddr == `TMR_OFF_MATCH) begin
            match_q <= pwdata[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Capture cause and interrupt
    // ------------------------------------------------------------
    // Capture sets the flag; reload in capture mode clears it.
    // If both happen on one edge the capture wins.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_cause_flag_q <= 1'b0;
        end else if (cap_edge) begin
            capture_cause_flag_q <= 1'b1; // R16
        end else if (at_reload && is_cap) begin
            capture_cause_flag_q <= 1'b0; // R17
        end
    end

    // One-cycle interrupt pulse per edge with an admitted event; a capture and a reload on one edge give one pulse.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (cap_edge && irq_on_cap) ||
                (at_reload && irq_on_reload); // R3 R17
        end
    end

    assign timer_irq = irq_q;

    // ------------------------------------------------------------
    // PWM level
    // ------------------------------------------------------------
    // Stopped, the level rests at the start level chosen by the
    // polarity; reload restores it and match turns it round.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_lvl_q <= 1'b0;
        end else if (!is_pwm || at_reload) begin
            pwm_lvl_q <= output_polarity_select_q; // R4 R5
        end else if (at_match) begin
            pwm_lvl_q <= !output_polarity_select_q; // R2 R4 R5
        end
    end

    // ------------------------------------------------------------
    // Output stage with deadband
    // ------------------------------------------------------------
    // Channel 0 is the main output, channel 1 its complement.
    // Outside dual mode the delay is zero and the complement off.
    deadband_if #(.DB_W(DB_W)) dbi [2] ();

    assign dbi[0].req = pwm_lvl_q;
    assign dbi[1].req = is_dual && !pwm_lvl_q; // R10

    for (genvar i = 0; i < 2; i++) begin : g_db
        assign dbi[i].delay = is_dual ? deadband_q : '0; // R11
        deadband_delay #(
            .DB_W(DB_W)
        ) u_db (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .db(dbi[i])
        );
    end

    assign tout = dbi[0].level;
    // The input pin turns into the complement output in dual mode.
    assign tin_oe = is_dual; // R13
    assign tin_out = dbi[1].level; // R10

endmodule

// ===== verif/timer_checker.sv
`timescale 1ns/100ps
`include "timer_defs.svh"

// ----------------------------------------------------------------
// Port checker for the timer
// ----------------------------------------------------------------
// Watches only the top ports.
module timer_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TMR_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tin_in,
    input wire logic tin_out,
    input wire logic tin_oe,
    input wire logic tout,
    input wire logic timer_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Zero wait states.
    chk_apb_no_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    // Words past 0x18 are unmapped.
    chk_err_decode: assert property (psel && penable && paddr[1:0] == 2'b00
        |-> pslverr == (paddr > 8'h18))
        else $error("pslverr does not match address decode");
    // Upper read bits are zero.
    chk_upper_zero: assert property (prdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    chk_irq_pulse: assert property (timer_irq |=> !timer_irq)
        else $error("interrupt wider than one cycle");
    // Outputs settle by the second edge held in reset.
    chk_reset_quiet: assert property (disable iff (1'b0)
        !arst_n [*2] |-> !tout && !timer_irq && !tin_oe)
        else $error("outputs active during reset");
    chk_comp_excl: assert property (tin_oe |-> !(tout && tin_out))
        else $error("both outputs high together");
    // Complement rises after the main output falls.
    chk_comp_rise: assert property (tin_oe && $fell(tout)
        |-> ##[1:131] tin_out)
        else $error("complement did not rise after deadband");
    // Pin role changes only on a write.
    chk_oe_by_write: assert property ($changed(tin_oe)
        |-> $past(psel && penable && pwrite))
        else $error("pin direction changed without a write");

    cov_irq: cover property (timer_irq);
    cov_dual_rise: cover property (tin_oe && $rose(tin_out));
    cov_bad_addr: cover property (pslverr);
endmodule

bind pwm_capture_timer timer_checker u_chk (.*);

// ===== verif/pin_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Outside circuit on the shared input pin
// ----------------------------------------------------------------
// The pin has a pull-up, so an undriven pin reads high.
module pin_model (
    input wire logic tin_out,
    input wire logic tin_oe,
    input wire logic ext_en,
    input wire logic ext_level,
    output logic tin_in
);
    // The timer owns the pin while it drives; the source backs off.
    assign tin_in = tin_oe ? tin_out : (ext_en ? ext_level : 1'b1);
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
`include "timer_defs.svh"

// Compares a value with its expectation and counts the outcome.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end

module tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`TMR_ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tin_in, tin_out, tin_oe, tout, timer_irq;
    logic ext_en = 1'b1; // Outside source drives the input pin.
    logic ext_level = 1'b1; // Level the outside source drives.
    logic msel = 1'b0; // Selects which output is measured.
    wire logic mon = msel ? tin_out : tout;
    int failures = 0;
    int tests_run = 0;
    int irq_cnt = 0; // Running count of interrupt pulses.
    int base, a, b, hi, per;
    logic [31:0] rv, m;
    logic er;

    // ------------------------------------------------------------
    // Clock, pulse counter and design
    // ------------------------------------------------------------
    always #50 ref_clk = ~ref_clk;

    // Pulses last one cycle, so each sampled high is one event.
    always @(posedge ref_clk) begin
        if (timer_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    pwm_capture_timer u_dut (.*);

    pin_model u_pin (.*);

    // ------------------------------------------------------------
    // Bus and measurement tasks
    // ------------------------------------------------------------
    // One APB transfer; the request holds until pready is sampled.
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ad, d, r, e);
        `CHK(e, 1'b0)
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] r);
        logic e;
        apb(1'b0, ad, 32'h0, r, e);
        `CHK(e, 1'b0)
    endtask

    // Cycles until the next interrupt pulse, bounded.
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (timer_irq !== 1'b1 && n < 2000);
    endtask

    // High time and period of the selected output, from a rising edge.
    task automatic meas(output int h, output int p);
        int g;
        g = 0;
        do begin
            @(posedge ref_clk);
            g++;
        end while (mon !== 1'b0 && g < 999);
        do begin
            @(posedge ref_clk);
            g++;
        end while (mon !== 1'b1 && g < 1999);
        h = 0;
        do begin
            @(posedge ref_clk);
            h++;
        end while (mon === 1'b1 && h < 999);
        p = h;
        do begin
            @(posedge ref_clk);
            p++;
        end while (mon !== 1'b1 && p < 999);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Ends a hung run.
    initial begin
        #(100 * 50000);
        failures++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(tout, 1'b0)
        rd(`TMR_OFF_CTL1, rv);
        `CHK(rv, 32'h0)
        apb(1'b0, 8'h40, 32'h0, rv, er);
        `CHK({er, rv}, 33'h1_0000_0000)
        // Single output, both polarities.
        wr(`TMR_OFF_PRESCALE, 32'h2);
        wr(`TMR_OFF_MATCH, 32'h3);
        wr(`TMR_OFF_RELOAD, 32'h8);
        for (int p = 0; p < 2; p++) begin
            wr(`TMR_OFF_CTL1, 32'h03 | (32'(p) << 6));
            wr(`TMR_OFF_COUNT, 32'h1);
            wr(`TMR_OFF_CTL1, 32'h83 | (32'(p) << 6));
            meas(hi, per);
            `CHK(hi, (p == 1) ? 6 : 10)
            `CHK(per, 16)
            wait_irq(a);
            wait_irq(b);
            `CHK(b, 16)
            rd(`TMR_OFF_COUNT, rv);
            `CHK(rv[15:0] >= 16'h1 && rv[15:0] <= 16'h8, 1'b1)
        end
        // A start count near reload shortens only the first period.
        wr(`TMR_OFF_CTL1, 32'h03);
        wr(`TMR_OFF_COUNT, 32'h7);
        wr(`TMR_OFF_CTL1, 32'h83);
        wait_irq(a);
        wait_irq(b);
        `CHK(a < 10, 1'b1)
        `CHK(b, 16)
        // Dual output; the source releases the pin.
        ext_en <= 1'b0;
        wr(`TMR_OFF_CTL1, 32'h00);
        wr(`TMR_OFF_CTL0, 32'h1);
        wr(`TMR_OFF_DEADBAND, 32'd200);
        rd(`TMR_OFF_DEADBAND, rv);
        `CHK(rv, 32'(`TMR_DB_MAX))
        `CHK(tin_oe, 1'b1)
        for (int d = 2; d >= 0; d -= 2) begin
            wr(`TMR_OFF_CTL1, 32'h00);
            wr(`TMR_OFF_DEADBAND, 32'(d));
            wr(`TMR_OFF_COUNT, 32'h1);
            wr(`TMR_OFF_CTL1, 32'h80);
            msel <= 1'b0;
            meas(hi, per);
            `CHK(hi, 10 - d)
            `CHK(per, 16)
            msel <= 1'b1;
            meas(hi, per);
            `CHK(hi, 6 - d)
        end
        // Leave dual mode once settled.
        wr(`TMR_OFF_CTL1, 32'h00);
        repeat (10) @(posedge ref_clk);
        wr(`TMR_OFF_CTL0, 32'h0);
        ext_en <= 1'b1;
        // Capture with each interrupt source.
        for (int i = 0; i < 3; i++) begin
            ext_level <= (i != 1);
            wr(`TMR_OFF_CTL1, 32'h04 | ((i == 1) ? 32'h40 : 32'h0));
            wr(`TMR_OFF_CTL0, 32'(i) << 1);
            wr(`TMR_OFF_PRESCALE, 32'h1);
            wr(`TMR_OFF_COUNT, 32'h1);
            wr(`TMR_OFF_RELOAD, 32'h40);
            wr(`TMR_OFF_MATCH, 32'h0);
            `CHK(tin_oe, 1'b0)
            wr(`TMR_OFF_CTL1, 32'h84 | ((i == 1) ? 32'h40 : 32'h0));
            repeat (10) @(posedge ref_clk);
            base = irq_cnt;
            ext_level <= (i == 1);
            repeat (5) @(posedge ref_clk);
            `CHK(irq_cnt - base, (i != 2) ? 1 : 0)
            rd(`TMR_OFF_CTL0, rv);
            `CHK(rv[3], 1'b1)
            rd(`TMR_OFF_MATCH, m);
            `CHK(m[15:0] > 16'h0 && m[15:0] < 16'h40, 1'b1)
            rd(`TMR_OFF_COUNT, rv);
            `CHK(rv[15:0] > m[15:0], 1'b1)
            repeat (70) @(posedge ref_clk);
            `CHK(irq_cnt - base, (i == 0) ? 2 : 1)
            rd(`TMR_OFF_CTL0, rv);
            `CHK(rv[3], 1'b0)
            rd(`TMR_OFF_MATCH, rv);
            `CHK(rv, m)
        end
        finish_test();
    end
endmodule
